// File: hw/led_pwm_channel.v
// one pwm channel: period divider, step counter, duty compare
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

module led_pwm_channel (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // timebase
    input wire step_tick,
    // settings from software
    input wire enable,
    input wire [2:0] rate,
    input wire [3:0] duty,
    // pin and state
    output reg level_q,
    output reg oe_q,
    output reg running_q
);
    reg [2:0] act_rate_q;
    reg [3:0] act_duty_q;
    reg [10:0] div_q;
    reg [3:0] step_q;
    reg [10:0] limit;
    reg rate_ok;

    always @* begin
        rate_ok = 1'b1;
        case (act_rate_q)
            `LED_RATE_0P25: limit = `LED_TICKS_0P25;
            `LED_RATE_0P5: limit = `LED_TICKS_0P5;
            `LED_RATE_1: limit = `LED_TICKS_1;
            `LED_RATE_2: limit = `LED_TICKS_2;
            `LED_RATE_128: limit = `LED_TICKS_128;
            `LED_RATE_256: limit = `LED_TICKS_256;
            default: begin
                limit = `LED_TICKS_256;
                rate_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= 1'b0;
            act_rate_q <= 3'h0;
            act_duty_q <= 4'h0;
            div_q <= 11'h000;
            step_q <= 4'h0;
        end else if (!enable) begin
            running_q <= 1'b0;
            div_q <= 11'h000;
            step_q <= 4'h0;
        end else if (!running_q) begin
            running_q <= 1'b1;
            act_rate_q <= rate;
            act_duty_q <= duty;
            div_q <= 11'h000;
            step_q <= 4'h0;
        end else if (step_tick) begin
            if (div_q == limit - 11'h001) begin
                div_q <= 11'h000;
                step_q <= step_q + 4'h1;
                if (step_q == `LED_STEPS_LAST) begin
                    act_rate_q <= rate;
                    act_duty_q <= duty;
                end
            end else begin
                div_q <= div_q + 11'h001;
            end
        end
    end

    // high for steps 0..duty, i.e. (duty+1)/16 of the period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            level_q <= running_q && enable && rate_ok && (step_q <= act_duty_q);
            oe_q <= running_q && enable;
        end
    end
endmodule // led_pwm_channel
`default_nettype wire

// File: hw/led_pwm_defines.vh
// constants for the four-channel led pwm bank
`ifndef LED_PWM_DEFINES_VH
`define LED_PWM_DEFINES_VH

// timebase: system clock and the rate of one pwm step (1/16 period at 256 Hz)
`define LED_CLK_HZ 100000000
`define LED_STEP_HZ 4096
`define LED_STEP_DIV (`LED_CLK_HZ / `LED_STEP_HZ)

// register byte offsets
`define LED_CH0_OFS 8'h00
`define LED_CH1_OFS 8'h04
`define LED_CH2_OFS 8'h08
`define LED_CH3_OFS 8'h0C
`define LED_STATUS_OFS 8'h10

// channel register fields
`define LED_RATE_LSB 0
`define LED_RATE_MSB 2
`define LED_DUTY_LSB 4
`define LED_DUTY_MSB 7
`define LED_EN_BIT 8
`define LED_CH_RESET 9'h000

// status register fields
`define LED_ST_LEVEL_LSB 0
`define LED_ST_RUN_LSB 4
`define LED_ST_OE_LSB 8

// rate codes and step ticks per pwm step
`define LED_RATE_0P25 3'h0
`define LED_RATE_0P5 3'h1
`define LED_RATE_1 3'h2
`define LED_RATE_2 3'h3
`define LED_RATE_128 3'h4
`define LED_RATE_256 3'h5
`define LED_TICKS_0P25 11'h400
`define LED_TICKS_0P5 11'h200
`define LED_TICKS_1 11'h100
`define LED_TICKS_2 11'h080
`define LED_TICKS_128 11'h002
`define LED_TICKS_256 11'h001

`define LED_STEPS_LAST 4'hF
`define LED_DUTY_FULL 4'hF

`endif

// File: hw/led_pwm_driver_bank.v
// four-channel led pwm bank with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

// Overview of operation
// - four channels drive general pins three-six
// - pin pwm only while channel enable set
// - rate codes 0-5 select pwm period, codes 6-7 hold pin low
// - duty code n gives (n+1)/16 high
// - host programs separate codes per channel
module led_pwm_driver_bank #(
    parameter STEP_DIV = `LED_STEP_DIV,
    parameter CHANNELS = 4
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    // led pins (general pins three to six)
    output wire [CHANNELS-1:0] led_out,
    output wire [CHANNELS-1:0] led_oe
);
    wire step_tick;
    wire [CHANNELS-1:0] running;
    reg [8:0] ch_reg_q [0:CHANNELS-1];
    reg [CHANNELS-1:0] wr_sel;
    reg [8:0] rd_ch;
    reg rd_hit;
    wire setup = psel && !penable;
    integer i;
    integer j;

    // apb phase strobes
    wire access = psel && penable;
    wire wr_access = access && pwrite;
    wire rd_setup = setup && !pwrite;

    // field views of every setting register
    wire [CHANNELS-1:0] en_f;
    wire [3*CHANNELS-1:0] rate_f;
    wire [4*CHANNELS-1:0] duty_f;

    // read word candidates, chosen in setup
    reg [31:0] status_word;
    reg [31:0] chan_word;
    reg [31:0] rd_word;
    reg err_word;
    reg [CHANNELS-1:0] wr_en;

    genvar f;
    generate
        for (f = 0; f < CHANNELS; f = f + 1) begin : g_field
            assign en_f[f] = ch_reg_q[f][`LED_EN_BIT];
            assign rate_f[3*f+2:3*f] = ch_reg_q[f][`LED_RATE_MSB:`LED_RATE_LSB];
            assign duty_f[4*f+3:4*f] = ch_reg_q[f][`LED_DUTY_MSB:`LED_DUTY_LSB];
        end
    endgenerate

    // status word: drive, running and level of every pin
    always @* begin
        status_word = 32'h00000000;
        status_word[`LED_ST_LEVEL_LSB +: CHANNELS] = led_out;
        status_word[`LED_ST_RUN_LSB +: CHANNELS] = running;
        status_word[`LED_ST_OE_LSB +: CHANNELS] = led_oe;
    end

    // channel word: setting bits, upper bits read zero
    always @* begin
        chan_word = 32'h00000000;
        chan_word[8:0] = rd_ch;
    end

    // word and error shown in the next access phase
    always @* begin
        rd_word = 32'h00000000;
        err_word = 1'b0;
        if (!rd_hit) begin
            err_word = 1'b1;
        end else if (!rd_setup) begin
            rd_word = 32'h00000000;
        end else if (paddr == `LED_STATUS_OFS) begin
            rd_word = status_word;
        end else begin
            rd_word = chan_word;
        end
    end

    // write strobes, one per channel
    always @* begin
        for (j = 0; j < CHANNELS; j = j + 1) begin
            wr_en[j] = wr_access && wr_sel[j];
        end
    end

    led_step_timebase #(
        .STEP_DIV(STEP_DIV)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .step_tick_q(step_tick)
    );

    // address decode
    always @* begin
        wr_sel = {CHANNELS{1'b0}};
        rd_ch = 9'h000;
        rd_hit = 1'b1;
        if (paddr == `LED_CH0_OFS) begin
            wr_sel[0] = 1'b1;
            rd_ch = ch_reg_q[0];
        end else if (paddr == `LED_CH1_OFS) begin
            wr_sel[1] = 1'b1;
            rd_ch = ch_reg_q[1];
        end else if (paddr == `LED_CH2_OFS) begin
            wr_sel[2] = 1'b1;
            rd_ch = ch_reg_q[2];
        end else if (paddr == `LED_CH3_OFS) begin
            wr_sel[3] = 1'b1;
            rd_ch = ch_reg_q[3];
        end else if (paddr == `LED_STATUS_OFS) begin
            rd_ch = 9'h000;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // per-channel setting registers, written in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                ch_reg_q[i] <= `LED_CH_RESET;
            end
        end else begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (wr_en[i]) begin
                    ch_reg_q[i] <= pwdata[8:0];
                end
            end
        end
    end

    // ready: zero wait states once out of reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
        end
    end

    // error flag prepared in setup, held until the next setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= err_word;
        end
    end

    // read data prepared in setup, held until the next setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= rd_word;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            led_pwm_channel u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .step_tick(step_tick),
                .enable(en_f[g]),
                .rate(rate_f[3*g+2:3*g]),
                .duty(duty_f[4*g+3:4*g]),
                .level_q(led_out[g]),
                .oe_q(led_oe[g]),
                .running_q(running[g])
            );
        end
    endgenerate
endmodule // led_pwm_driver_bank
`default_nettype wire

// File: hw/led_step_timebase.v
// shared step timebase: one-cycle tick at the pwm step rate
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

module led_step_timebase #(
    parameter STEP_DIV = `LED_STEP_DIV
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // tick out
    output reg step_tick_q
);
    reg [15:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            step_tick_q <= 1'b0;
        end else if (cnt_q == STEP_DIV[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            step_tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            step_tick_q <= 1'b0;
        end
    end
endmodule // led_step_timebase
`default_nettype wire

// File: tb/led_load.sv
// led load on the general pins, pulled low when released
`timescale 1ns/1ps
`default_nettype none
module led_load (
    // pin drive
    input wire logic [3:0] led_out,
    input wire logic [3:0] led_oe,
    // level seen
    output wire logic [3:0] pin
);
    assign pin = led_out & led_oe;
endmodule // led_load
`default_nettype wire

// File: tb/led_pwm_chk.sv
// assertion checker for the led pwm bank ports
`timescale 1ns/1ps
`default_nettype none
module led_pwm_chk #(
    parameter STEP_DIV = 4,
    parameter CHANNELS = 4
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_q,
    input wire logic pready_q,
    input wire logic pslverr_q,
    // pins
    input wire logic [CHANNELS-1:0] led_out,
    input wire logic [CHANNELS-1:0] led_oe
);
    wire wr0 = psel && penable && pwrite && paddr == 8'h00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc; psel && penable; endsequence
    sequence bad; psel && penable && (paddr > 8'h10 || paddr[1:0] != 2'h0); endsequence
    sequence off0; wr0 && !pwdata[8]; endsequence
    AST_PREADY: assert property (acc |-> pready_q) else $error("access without ready");
    AST_ERR: assert property (bad |-> pslverr_q && prdata_q == 32'h0) else $error("unmapped not refused");
    AST_NOERR: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr_q)
        else $error("mapped access refused");
    AST_HIGH: assert property (acc |-> prdata_q[31:12] == 20'h0) else $error("upper read bits set");
    AST_OUTOE: assert property ((led_out & ~led_oe) == {CHANNELS{1'b0}}) else $error("level on released pin");
    AST_OFF: assert property (off0 |-> ##3 !led_oe[0] && !led_out[0]) else $error("pin still driven");
    AST_LOW: assert property ($fell(led_out[0]) && led_oe[0] |-> !led_out[0] [*3]) else $error("low step short");
    AST_OECAUSE: assert property ($changed(led_oe[0]) |-> $past(wr0, 1) || $past(wr0, 2) || $past(wr0, 3))
        else $error("drive changed without write");
endmodule // led_pwm_chk
bind led_pwm_driver_bank led_pwm_chk #(.STEP_DIV(STEP_DIV), .CHANNELS(CHANNELS)) led_pwm_chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .led_out(led_out), .led_oe(led_oe));
`default_nettype wire

// File: tb/led_pwm_driver_bank_test.sv
// self-checking bench for the led pwm bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s %0h %0h", n, e, g); end end
module led_pwm_driver_bank_test;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata_q;
    wire pready_q, pslverr_q;
    wire [3:0] led_out, led_oe, pin;
    int err_total = 0, comparisons = 0;
    logic [31:0] h [4];
    int dl [3] = '{0, 7, 15};
    row_t rows [5] = '{'{8'h00, 32'hFFFFF175, 32'h175, 0}, '{8'h04, 32'h134, 32'h134, 0},
        '{8'h08, 32'h1F6, 32'h1F6, 0}, '{8'h0C, 32'h0F5, 32'h0F5, 0}, '{8'h14, 32'h1FF, 32'h0, 1}};
    always #5 pclk = ~pclk;
    led_pwm_driver_bank #(.STEP_DIV(4), .CHANNELS(4)) led_pwm_driver_bank_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .led_out(led_out), .led_oe(led_oe));
    led_load led_load_i (.led_out(led_out), .led_oe(led_oe), .pin(pin));
    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready_q !== 1'b1 && n < 50);
        if (n >= 50) begin err_total++; print_verdict(); end
        rd = prdata_q;
        er = pslverr_q;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic meas();
        for (int i = 0; i < 4; i++) h[i] = 0;
        repeat (128) begin @(posedge pclk); for (int i = 0; i < 4; i++) h[i] += pin[i]; end
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rows[k]) begin
            apb(1, rows[k].a, rows[k].w);
            apb(0, rows[k].a, 32'h0);
            `CHK("rdata", rows[k].r, rd)
            `CHK("slverr", rows[k].e, er)
        end
        apb(1, 8'h10, 32'hFFF);
        `CHK("st_err", 1'b0, er)
        apb(0, 8'h10, 32'h0);
        `CHK("status", 8'h77, rd[11:4])
        foreach (dl[j]) begin
            apb(1, 8'h00, 32'h105 | (dl[j] << 4));
            repeat (200) @(posedge pclk);
            meas();
            `CHK("high0", 32'(8 * (dl[j] + 1)), h[0])
            `CHK("high1", 32'd32, h[1])
            `CHK("high2", 32'd0, h[2])
            `CHK("high3", 32'd0, h[3])
        end
        apb(1, 8'h00, 32'h075);
        repeat (3) @(posedge pclk);
        `CHK("oe0", 1'b0, led_oe[0])
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK("oe_rst", 4'h0, led_oe)
        apb(0, 8'h04, 32'h0);
        `CHK("reset", 32'h0, rd)
        print_verdict();
    end
endmodule // led_pwm_driver_bank_test
`default_nettype wire
